// [src/cia_device.sv]
// Device end: address port, data window and six internal registers
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Address write, then data access uses index
// - Address port holds across data accesses
// - Select high address port, low data
// - Host writes reserved address bits as zero
// - Width bit set means 8-bit transfers
// - Host keeps width bit constant
// - Bits 3:1 index registers zero to five
// - Narrow mode lane bit picks high byte
// - Host clears lane bit in wide mode
// - Reset clears whole address port
// - Data write loads, read returns register
// - Only two locations visible on bus
module cia_device
(
   input  wire logic        clk_i,       // System clock
   input  wire logic        rst_i,       // Asynchronous reset, high
   cia_if.dev               bus,         // Slave bus
   output logic [15:0]      reg_val_o [6], // Register contents to core
   output logic             narrow_o     // 8-bit mode in force
);
   // Access sequence as seen on the slave bus:
   //   1. A strobe with the select pin high and write set loads the
   //      address port; reserved positions are masked off on the way in.
   //   2. Any later strobe with the select pin low reaches the register
   //      named by the index field, through the lane that the width and
   //      lane bits choose.
   // A data access never touches the index, so software may stream many
   // data accesses after one address write. The price is that a driver
   // must rewrite the index after any other code has used the port.
   // Width changes take effect on the very next data access; the host is
   // expected never to flip the width bit in normal operation, and no
   // attempt is made here to make such a flip harmless.
   // Read data is registered, so it appears one cycle after the strobe,
   // with a one-cycle valid pulse; the data itself holds until the next
   // read so a slow host may pick it up later.
   // Back to back strobes are fine: every strobe is taken on its own
   // edge and nothing here needs a recovery cycle.

   // All state in one struct, so reset and update stay in one place
   typedef struct packed
   {
      logic [15:0]      index;  // Address port, reserved bits held zero
      logic [5:0][15:0] regs;   // Internal registers, index 0 in [0]
      logic [15:0]      rdata;  // Read data, holds until next read
      logic             rvalid; // Read valid pulse, one cycle
   } cia_dev_s;

   // Reset image of the whole state; index zero means 16-bit mode
   localparam cia_dev_s DEV_RESET = '{
      index:  cia_pkg::INDEX_RESET,
      regs:   {cia_pkg::NUM_REGS{cia_pkg::REG_RESET}},
      rdata:  cia_pkg::REG_RESET,
      rvalid: 1'b0
   };

   cia_dev_s st_r;   // Registered state
   cia_dev_s st_nxt; // Next state, filled by one combinational process

   logic [2:0]  idx;    // Register index field of the address port
   logic        narrow; // 8-bit mode in force
   logic        hi;     // Lane select, meaningful in 8-bit mode only
   logic        hit;    // Index names one of the six registers
   logic [15:0] cur;    // Selected register value, zero for empty index

   // Merge a bus write into a register word; a narrow write changes
   // one byte and leaves the other as it was
   function automatic logic [15:0] merge_wr
   (
      input logic [15:0] old_val, // Register before the write
      input logic [15:0] bus_val, // Word on the bus
      input logic        narrow,  // 8-bit mode in force
      input logic        upper    // High byte addressed
   );
      logic [15:0] res; // Merged word
      res = old_val;
      if (!narrow)
      begin
         // Wide mode: the whole word is replaced
         res = bus_val;
      end
      else if (upper)
      begin
         // Narrow byte always travels in the low lane of the bus
         res[15:8] = bus_val[7:0];
      end
      else
      begin
         // Low byte addressed; the upper bus lane is ignored
         res[7:0] = bus_val[7:0];
      end
      return res;
   endfunction : merge_wr

   // Shape a register word for the bus; narrow reads return the chosen
   // byte in the low lane with the upper lane zero
   function automatic logic [15:0] format_rd
   (
      input logic [15:0] reg_val, // Selected register contents
      input logic        narrow,  // 8-bit mode in force
      input logic        upper    // High byte addressed
   );
      logic [15:0] res; // Word to return
      res = reg_val;
      if (narrow)
      begin
         if (upper)
         begin
            res = {8'h00, reg_val[15:8]};
         end
         else
         begin
            res = {8'h00, reg_val[7:0]};
         end
      end
      return res;
   endfunction : format_rd

   // Field decode of the address port
   always_comb
   begin
      idx = st_r.index[cia_pkg::FIELD_MSB:cia_pkg::FIELD_LSB];
      narrow = st_r.index[cia_pkg::NARROW_BIT];
      // Lane bit is decoded in wide mode too; it is ignored there
      hi = st_r.index[cia_pkg::LANE_BIT];
      // Indices six and seven name no register
      hit = (idx <= cia_pkg::LAST_INDEX);
      cur = hit ? st_r.regs[idx] : 16'h0000;
   end

   // Next state: address writes, data window reads and writes
   always_comb
   begin
      st_nxt = st_r;
      // Valid is a one-cycle pulse; it drops unless a read is taken now
      st_nxt.rvalid = 1'b0;
      if (bus.sel)
      begin
         // Only the two ports exist; the select pin picks one
         if (bus.port_sel == cia_pkg::SEL_ADDRESS)
         begin
            if (bus.we)
            begin
               // Reserved bits not stored, so they read back zero
               st_nxt.index = bus.wdata & cia_pkg::INDEX_WMASK;
            end
            else
            begin
               // Address port read back, for driver debug
               st_nxt.rdata  = st_r.index;
               st_nxt.rvalid = 1'b1;
            end
         end
         else
         begin
            // Data access leaves the index untouched
            if (bus.we)
            begin
               // Writes to an empty index are dropped
               if (hit)
               begin
                  st_nxt.regs[idx] = merge_wr(cur, bus.wdata, narrow, hi);
               end
            end
            else
            begin
               // Empty index reads zero because cur is zero there
               st_nxt.rdata  = format_rd(cur, narrow, hi);
               st_nxt.rvalid = 1'b1;
            end
         end
      end
   end

   // State register; reset clears address port to wide mode
   // The reset branch loads a constant image only, so the asynchronous
   // path never depends on live logic
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r <= DEV_RESET;
      end
      else
      begin
         // Every field moves on every edge; holding is done in st_nxt
         st_r <= st_nxt;
      end
   end

   // Register contents fan out to the core straight from flip-flops
   always_comb
   begin
      for (int i = 0; i < cia_pkg::NUM_REGS; i++)
      begin
         reg_val_o[i] = st_r.regs[i];
      end
   end

   // Mode flag and read path are flip-flop bits, no logic in between
   assign narrow_o   = narrow;
   assign bus.rdata  = st_r.rdata;
   assign bus.rvalid = st_r.rvalid;
endmodule : cia_device
`default_nettype wire

// [src/cia_host.sv]
// Host end: turns one register request into address and data transactions
`timescale 1ns/10ps
`default_nettype none
module cia_host
(
   input  wire logic        clk_i,     // System clock
   input  wire logic        rst_i,     // Asynchronous reset, high
   input  wire logic        req_i,     // Start request, taken when ready_o
   input  wire logic        we_i,      // Write request
   input  wire logic [2:0]  index_i,   // Register index
   input  wire logic        narrow_i,  // Width mode to program
   input  wire logic        hi_i,      // High lane (narrow only)
   input  wire logic [15:0] wdata_i,   // Write data
   output logic             ready_o,   // Idle, can take a request
   output logic             done_o,    // Completion pulse
   output logic [15:0]      rdata_o,   // Read result
   cia_if.host              bus        // Slave bus
);
   // All host state in one struct
   typedef struct packed
   {
      cia_pkg::cia_state_e state; // Sequencer
      logic                we;    // Held request kind
      logic [15:0]         addr;  // Address word to write
      logic [15:0]         wdata; // Held write data
      logic [15:0]         rdata; // Captured read
      logic                done;  // Completion pulse
   } cia_host_s;

   cia_host_s st_r;   // Registered state
   cia_host_s st_nxt; // Next state

   // Sequencer: address write first, data access second
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      case (st_r.state)
         cia_pkg::CIA_IDLE:
         begin
            if (req_i)
            begin
               st_nxt.we    = we_i;
               // Lane forced zero in wide mode, reserved bits zero
               st_nxt.addr  = cia_pkg::cia_index_word(narrow_i, index_i,
                                 narrow_i & hi_i);
               st_nxt.wdata = wdata_i;
               st_nxt.state = cia_pkg::CIA_ADDR;
            end
         end
         cia_pkg::CIA_ADDR:
         begin
            st_nxt.state = cia_pkg::CIA_DATA;
         end
         cia_pkg::CIA_DATA:
         begin
            if (st_r.we)
            begin
               st_nxt.done  = 1'b1;
               st_nxt.state = cia_pkg::CIA_IDLE;
            end
            else
            begin
               st_nxt.state = cia_pkg::CIA_DONE;
            end
         end
         cia_pkg::CIA_DONE:
         begin
            // Read data returns one cycle after the strobe
            if (bus.rvalid)
            begin
               st_nxt.rdata = bus.rdata;
               st_nxt.done  = 1'b1;
               st_nxt.state = cia_pkg::CIA_IDLE;
            end
         end
         default:
         begin
            st_nxt.state = cia_pkg::CIA_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r.state <= cia_pkg::CIA_IDLE;
         st_r.we    <= 1'b0;
         st_r.addr  <= cia_pkg::INDEX_RESET;
         st_r.wdata <= cia_pkg::REG_RESET;
         st_r.rdata <= cia_pkg::REG_RESET;
         st_r.done  <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Bus drive; select pin driven on every transaction
   always_comb
   begin
      bus.sel      = (st_r.state == cia_pkg::CIA_ADDR) ||
                     (st_r.state == cia_pkg::CIA_DATA);
      bus.port_sel = (st_r.state == cia_pkg::CIA_ADDR) ?
                     cia_pkg::SEL_ADDRESS : cia_pkg::SEL_DATA;
      bus.we       = (st_r.state == cia_pkg::CIA_ADDR) || st_r.we;
      bus.wdata    = (st_r.state == cia_pkg::CIA_ADDR) ?
                     st_r.addr : st_r.wdata;
   end

   assign ready_o = (st_r.state == cia_pkg::CIA_IDLE);
   assign done_o  = st_r.done;
   assign rdata_o = st_r.rdata;
endmodule : cia_host
`default_nettype wire

// [src/cia_if.sv]
// Slave bus between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
interface cia_if;
   logic        sel;      // Slave select strobe
   logic        we;       // Write when high
   logic        port_sel; // High: address port, low: data port
   logic [15:0] wdata;    // Write data
   logic [15:0] rdata;    // Read data, valid cycle after strobe
   logic        rvalid;   // Read data valid pulse

   modport dev  (input sel, we, port_sel, wdata, output rdata, rvalid);
   modport host (output sel, we, port_sel, wdata, input rdata, rvalid);
endinterface : cia_if
`default_nettype wire

// [src/cia_pkg.sv]
// Constants and types shared by both ends of the indirect register port
package cia_pkg;
   localparam int unsigned DATA_W        = 16;             // Bus data width
   localparam int unsigned NUM_REGS      = 6;              // Internal registers
   localparam logic [15:0] INDEX_RESET   = 16'h0000;       // Address reg reset
   localparam logic [15:0] REG_RESET     = 16'h0000;       // Internal reg reset
   localparam int unsigned NARROW_BIT    = 7;              // Width select bit
   localparam int unsigned FIELD_LSB     = 1;              // Index field low
   localparam int unsigned FIELD_MSB     = 3;              // Index field high
   localparam int unsigned LANE_BIT      = 0;              // Byte lane bit
   localparam logic [15:0] INDEX_WMASK   = 16'h008f;       // Writable bits
   localparam logic [2:0]  LAST_INDEX    = 3'h5;           // Highest index
   localparam logic        SEL_ADDRESS   = 1'b1;           // Select high: addr
   localparam logic        SEL_DATA      = 1'b0;           // Select low: data

   // Host sequencer states, Gray coded along idle-addr-data-done
   typedef enum logic [1:0]
   {
      CIA_IDLE = 2'b00,
      CIA_ADDR = 2'b01,
      CIA_DATA = 2'b11,
      CIA_DONE = 2'b10
   } cia_state_e;

   // Build an address port value; reserved bits forced to zero
   function automatic logic [15:0] cia_index_word(input logic narrow,
                                                  input logic [2:0] idx,
                                                  input logic hi);
      cia_index_word = {8'h00, narrow, 3'h0, idx, hi};
   endfunction : cia_index_word
endpackage : cia_pkg

// [tb/cia_checker.sv]
// Bus checks between the host end and the device end
`timescale 1ns/10ps
`default_nettype none
module cia_checker
(
   input  wire logic        clk_i,    // System clock
   input  wire logic        rst_i,    // Async reset, high
   input  wire logic        sel,      // Slave strobe
   input  wire logic        we,       // Write when high
   input  wire logic        port_sel, // High: address port
   input  wire logic [15:0] wdata,    // Write data
   input  wire logic [15:0] rdata,    // Read data
   input  wire logic        rvalid    // Read data valid
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] index_r;              // Shadow of the address port
   logic        wrote_r;              // Address port written since reset
   // Shadow tracks address writes; masked so reserved bits never leak in
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         index_r <= 16'h0000;
         wrote_r <= 1'b0;
      end
      else if (sel && port_sel && we)
      begin
         index_r <= wdata & cia_pkg::INDEX_WMASK;
         wrote_r <= 1'b1;
      end
   end
   sequence s_addr;
      sel && port_sel && we;
   endsequence
   sequence s_data;
      sel && !port_sel;
   endsequence
   sequence s_rd;
      sel && !port_sel && !we;
   endsequence
   property p_two_step; s_addr |=> s_data; endproperty
   property p_pulse; s_data |=> !sel; endproperty
   property p_answer; s_rd |=> rvalid; endproperty
   property p_no_spur; !(sel && !we) |=> !rvalid; endproperty
   property p_reserved;
      s_addr |-> (wdata & ~cia_pkg::INDEX_WMASK) == 16'h0000;
   endproperty
   property p_lane; s_addr and !wdata[7] |-> !wdata[0]; endproperty
   property p_empty;
      s_rd and index_r[3:1] > 3'h5 |=> rdata == 16'h0000;
   endproperty
   property p_narrow; s_rd and index_r[7] |=> rdata[15:8] == 8'h00;
   endproperty
   // Reset itself is the cause here, so it must not disable the check;
   // the first reset edge is skipped as the reset event may race time zero
   property p_reset;
      disable iff (1'b0) rst_i && $past(rst_i) |-> !rvalid && !sel;
   endproperty
   property p_reset_exit; $fell(rst_i) |-> !rvalid && !sel && !we;
   endproperty
   property p_width;
      s_addr and wrote_r |-> wdata[7] == index_r[7];
   endproperty
   a_two_step: assert property (p_two_step)
      else $error("data strobe missing after address write");
   a_pulse: assert property (p_pulse)
      else $error("strobe held after data access");
   a_answer: assert property (p_answer)
      else $error("read without valid");
   a_no_spur: assert property (p_no_spur)
      else $error("valid without read");
   a_reserved: assert property (p_reserved)
      else $error("reserved address bits set");
   a_lane: assert property (p_lane)
      else $error("lane bit set in wide mode");
   a_empty: assert property (p_empty)
      else $error("unused index read not zero");
   a_narrow: assert property (p_narrow)
      else $error("narrow read upper byte not zero");
   a_reset: assert property (p_reset)
      else $error("bus active in reset");
   a_reset_exit: assert property (p_reset_exit)
      else $error("bus not idle after reset release");
   a_width: assert property (p_width)
      else $error("width bit changed between address writes");
endmodule : cia_checker
`default_nettype wire

// [tb/csr_indirect_access_port_test.sv]
// Bench: host end drives device end; user sides checked
`timescale 1ns/10ps
`default_nettype none
module csr_indirect_access_port_test;
   typedef struct {logic w; logic [2:0] ix; logic [15:0] d;} cia_row_s;
   logic        clk_i, rst_i, req_i, we_i, narrow_i, hi_i; // Host inputs
   logic        ready_o, done_o, narrow_o;   // Status outputs
   logic [2:0]  index_i;                     // Register index
   logic [15:0] wdata_i, rdata_o;            // Request data
   logic [15:0] reg_val_o [6];               // Device registers
   int          n_errors, n_checks, lat;     // Counters
   // Writes carry data, reads carry the expected value
   cia_row_s rows [9] = '{'{1'b1, 3'h0, 16'ha5a5}, '{1'b1, 3'h5, 16'h5a5a},
      '{1'b1, 3'h6, 16'hffff}, '{1'b0, 3'h0, 16'ha5a5},
      '{1'b0, 3'h5, 16'h5a5a}, '{1'b0, 3'h6, 16'h0000},
      '{1'b0, 3'h7, 16'h0000}, '{1'b1, 3'h3, 16'h1234},
      '{1'b0, 3'h3, 16'h1234}};
   cia_if bus_if ();
   cia_host i_cia_host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
      .we_i(we_i), .index_i(index_i), .narrow_i(narrow_i), .hi_i(hi_i),
      .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o),
      .rdata_o(rdata_o), .bus(bus_if));
   cia_device i_cia_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
      .reg_val_o(reg_val_o), .narrow_o(narrow_o));
   cia_checker i_cia_checker (.clk_i(clk_i), .rst_i(rst_i),
      .sel(bus_if.sel), .we(bus_if.we), .port_sel(bus_if.port_sel),
      .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
   // Clock, 10 ns period
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask : chk
   // One request; the wait is bounded so a dead host cannot hang the run
   task automatic op(input logic w, input logic [2:0] ix, input logic nw,
                     input logic hi, input logic [15:0] d);
      req_i = 1'b1;
      we_i = w;
      index_i = ix;
      narrow_i = nw;
      hi_i = hi;
      wdata_i = d;
      @(posedge clk_i);
      #1 req_i = 1'b0;
      // Count cycles from the request cycle, which is cycle zero
      lat = 1;
      while (done_o !== 1'b1 && lat < 10)
      begin
         @(posedge clk_i);
         #1 lat++;
      end
      chk(16'(lat), w ? 16'h0003 : 16'h0004);
      if (lat >= 10)
         final_report();
   endtask : op
   // Main sequence: reset, table, mid-run reset, narrow cases
   initial
   begin
      n_errors = 0;
      n_checks = 0;
      {req_i, we_i, narrow_i, hi_i, index_i, wdata_i} = '0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 rst_i = 1'b0;
      chk({15'h0, narrow_o}, 16'h0000);
      chk({15'h0, ready_o}, 16'h0001);
      foreach (rows[i])
      begin
         op(rows[i].w, rows[i].ix, 1'b0, 1'b0, rows[i].d);
         if (!rows[i].w)
            chk(rdata_o, rows[i].d);
      end
      chk(reg_val_o[0], 16'ha5a5);
      chk(reg_val_o[3], 16'h1234);
      chk(reg_val_o[1], 16'h0000);
      chk(reg_val_o[4], 16'h0000);
      chk(reg_val_o[5], 16'h5a5a);
      $display("table test done");
      rst_i = 1'b1;
      @(posedge clk_i);
      #1 rst_i = 1'b0;
      chk(reg_val_o[0], 16'h0000);
      op(1'b1, 3'h2, 1'b1, 1'b0, 16'h0034);
      op(1'b1, 3'h2, 1'b1, 1'b1, 16'h0012);
      chk({15'h0, narrow_o}, 16'h0001);
      chk(reg_val_o[2], 16'h1234);
      op(1'b0, 3'h2, 1'b1, 1'b1, 16'h0000);
      chk(rdata_o, 16'h0012);
      op(1'b0, 3'h2, 1'b1, 1'b0, 16'h0000);
      chk(rdata_o, 16'h0034);
      op(1'b0, 3'h7, 1'b1, 1'b0, 16'h0000);
      chk(rdata_o, 16'h0000);
      $display("narrow test done");
      final_report();
   end
endmodule : csr_indirect_access_port_test
`default_nettype wire
